// ---- error_class_pkg.sv ----
/*
  error codes, limits and timing constants for the request error classifier.
  assumes the includer refers to every item as error_class_pkg::name.
*/
`default_nettype none
package error_class_pkg;
  // negative response codes
  localparam logic [15:0] CODE_SYSTEM = 16'h0001;
  localparam logic [15:0] CODE_CONVERT = 16'h0011;
  localparam logic [15:0] CODE_COMMAND = 16'h0021;
  localparam logic [15:0] CODE_CMD_TYPE = 16'h0031;
  localparam logic [15:0] CODE_DEVICE_MEM = 16'h1132;
  localparam logic [15:0] CODE_DATA_SIZE = 16'h1232;
  localparam logic [15:0] CODE_DATA_TYPE = 16'h2432;
  localparam logic [15:0] CODE_FORMAT = 16'h7132;
  localparam logic [15:0] CODE_AREA = 16'h2232;
  localparam logic [15:0] CODE_MON_EXEC = 16'h0190;
  localparam logic [15:0] CODE_MON_REG = 16'h0290;
  localparam logic [15:0] CODE_UNSUPPORTED = 16'h6001;
  localparam logic [15:0] CODE_OVERRUN = 16'h6010;
  localparam logic [15:0] CODE_TIMEOUT = 16'h6020;
  localparam logic [15:0] CODE_SYNTAX = 16'h6030;
  localparam logic [15:0] CODE_LENGTH = 16'h6040;
  localparam logic [15:0] CODE_CHECK = 16'h6050;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  // limits
  localparam logic [8:0] MAX_DATA_BYTES = 9'h080;
  localparam logic [8:0] MAX_FRAME_TEXT = 9'h100;
  localparam logic [3:0] MAX_MONITOR_NO = 4'h9;
  localparam logic [6:0] OUTPUT_BIT_LIMIT = 7'h40;
  // frame characters
  localparam logic [7:0] CHAR_ENQ = 8'h05;
  localparam logic [7:0] CHAR_EOT = 8'h04;
  localparam logic [7:0] CHAR_PERCENT = 8'h25;
  localparam logic [7:0] CHAR_COMMA = 8'h2C;
  localparam logic [7:0] CHAR_DOT = 8'h2E;
  // frame receive timeout
  localparam int FRAME_TIMEOUT_US = 1000;
  localparam int CLK_MHZ = 200;
  localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * CLK_MHZ;
  localparam logic [17:0] TIMER_ZERO = 18'h00000;
  // reset values
  localparam logic [8:0] COUNT_ZERO = 9'h000;
endpackage
`default_nettype wire

// ---- host_frame_model.sv ----
/*
  host side model: sends one request frame per go pulse, one character a cycle.
  assumes go is a one-cycle pulse given only while no frame is in flight.
*/
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // frame request: mode 0 whole, 1 no end mark, 2 no start mark
  input wire logic go,
  input wire logic [1:0] mode,
  input wire logic [9:0] textLen,
  input wire logic [7:0] textChar,
  // characters toward the device
  output logic charValid,
  output logic [7:0] charData
);
  ////////////////////////////////////////////////////////////
  logic [9:0] idx; // next text position
  logic busy; // frame in flight
  // idle data is inverted each cycle so a stale character never passes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 10'h000;
      busy <= 1'b0;
      charValid <= 1'b0;
      charData <= 8'h00;
    end else if (go) begin
      busy <= 1'b1;
      idx <= 10'h001;
      charValid <= (mode != 2'h2);
      charData <= (mode != 2'h2) ? 8'h05 : ~charData;
    end else if (busy && idx <= textLen) begin
      idx <= idx + 10'h001;
      charValid <= 1'b1;
      charData <= textChar;
    end else begin
      busy <= 1'b0;
      charValid <= busy && (mode != 2'h1);
      charData <= (busy && mode != 2'h1) ? 8'h04 : ~charData;
    end
  end
endmodule
`default_nettype wire

// ---- serial_request_error_classifier.sv ----
/*
  classifies one received request frame into at most one error code.
  assumes a parser in the same clock domain presents each frame character as a
  one-cycle strobe and reports decoded fields (command, type, area, ...) as
  levels, sampled at frame end; uart faults arrive as pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - core unreachable reports system interface code
// R2 - illegal character reports conversion error
// R3 - only w r x y s accepted
// R4 - only individual or block type accepted
// R5 - only internal, output, input areas accepted
// R6 - data count 1 to 128 bytes
// R7 - only bit and word data types
// R8 - missing percent or output dots rejected
// R9 - address beyond area reports area exceeding
// R10 - monitor number above nine rejected
// R11 - unsupported command use rejected
// R12 - overrun or framing error reported
// R13 - frame reception timeout reported
// R14 - frame needs ENQ start, EOT end
// R15 - frame text limited to 256 bytes
// R16 - check character mismatch reported
// R17 - one code per rejection, keep serving
module serial_request_error_classifier #(
  parameter int TIMEOUT_CYC = error_class_pkg::FRAME_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // received characters
  input wire logic charValid,
  input wire logic [7:0] charData,
  input wire logic uartFault,
  // decoded request fields, valid at frame end
  input wire logic coreReady,
  input wire logic [7:0] cmdLetter,
  input wire logic typeIndividual,
  input wire logic typeBlock,
  input wire logic [7:0] areaLetter,
  input wire logic [7:0] typeLetter,
  input wire logic [8:0] dataBytes,
  input wire logic percentSeen,
  input wire logic outputBitRequest,
  input wire logic dotsSeen,
  input wire logic addrDecimal,
  input wire logic [6:0] outputBitIndex,
  input wire logic addrOverMemory,
  input wire logic monitorCmd,
  input wire logic monitorExec,
  input wire logic [3:0] monitorNo,
  input wire logic blockReadCommand,
  input wire logic bccMatch,
  // verdict
  output logic verdictValid,
  output logic verdictReject,
  output logic [15:0] errorCode
);

  ////////////////////////////////////////////////////////////////////////
  // state
  // one-hot phase of frame reception
  typedef enum logic [1:0] {
    IDLE = 2'b01,
    TEXT = 2'b10
  } phase_type;

  // all state of the classifier in one word
  typedef struct packed {
    phase_type phase;
    logic [8:0] textCount;
    logic [17:0] timer;
    logic badChar;
    logic lengthOver;
    logic uartErr;
    logic verdictValid;
    logic verdictReject;
    logic [15:0] errorCode;
  } state_type;

  state_type cur_r; // registered state
  state_type cur_nxt; // next state
  logic [15:0] fieldCode; // field check outcome
  logic isLetter; // character classes
  logic isDigit;
  logic [7:0] cmdLower; // lower-cased letters
  logic [7:0] areaLower;
  logic [7:0] typeLower;

  ////////////////////////////////////////////////////////////////////////
  // character class and field checks, first failing check wins
  always_comb begin
    // ascii classes of the character on the strobe
    isLetter = (charData >= 8'h41 && charData <= 8'h5A) || (charData >= 8'h61 && charData <= 8'h7A);
    isDigit = charData >= 8'h30 && charData <= 8'h39;
    // letters fold to lower case by setting bit 5
    cmdLower = cmdLetter | 8'h20;
    areaLower = areaLetter | 8'h20;
    typeLower = typeLetter | 8'h20;
    // accepted unless one of the checks below fails
    fieldCode = error_class_pkg::CODE_NONE;
    if (!coreReady) begin
      fieldCode = error_class_pkg::CODE_SYSTEM; // see R1
    end else if (!(cmdLower == 8'h77 || cmdLower == 8'h72 || cmdLower == 8'h78 ||
                   cmdLower == 8'h79 || cmdLower == 8'h73)) begin
      fieldCode = error_class_pkg::CODE_COMMAND; // see R3
    end else if (!(typeIndividual || typeBlock)) begin
      fieldCode = error_class_pkg::CODE_CMD_TYPE; // see R4
    end else if (monitorCmd && monitorNo > error_class_pkg::MAX_MONITOR_NO) begin
      fieldCode = monitorExec ? error_class_pkg::CODE_MON_EXEC : error_class_pkg::CODE_MON_REG; // see R10
    end else if (!percentSeen || (outputBitRequest && !dotsSeen)) begin
      fieldCode = error_class_pkg::CODE_FORMAT; // see R8
    end else if (!(areaLower == 8'h6D || areaLower == 8'h71 || areaLower == 8'h69)) begin
      fieldCode = error_class_pkg::CODE_DEVICE_MEM; // see R5
    end else if (!(typeLower == 8'h78 || typeLower == 8'h77)) begin
      fieldCode = error_class_pkg::CODE_DATA_TYPE; // see R7
    end else if (blockReadCommand && typeLower == 8'h78) begin
      fieldCode = error_class_pkg::CODE_UNSUPPORTED; // see R11
    end else if (dataBytes == error_class_pkg::COUNT_ZERO || dataBytes > error_class_pkg::MAX_DATA_BYTES) begin
      fieldCode = error_class_pkg::CODE_DATA_SIZE; // see R6
    end else if (!addrDecimal || addrOverMemory ||
                 (outputBitRequest && outputBitIndex >= error_class_pkg::OUTPUT_BIT_LIMIT)) begin
      fieldCode = error_class_pkg::CODE_AREA; // see R9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame tracking and verdict
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.verdictValid = 1'b0;
    // receiver faults are latched for the frame in flight
    if (uartFault) begin
      cur_nxt.uartErr = 1'b1; // see R12
    end
    case (cur_r.phase)
      IDLE: begin
        // wait for a start mark; anything else is stray text
        if (charValid && charData == error_class_pkg::CHAR_ENQ) begin
          cur_nxt.phase = TEXT; // see R14
          cur_nxt.textCount = error_class_pkg::COUNT_ZERO;
          cur_nxt.timer = error_class_pkg::TIMER_ZERO;
          cur_nxt.badChar = 1'b0;
          cur_nxt.lengthOver = 1'b0;
          cur_nxt.uartErr = uartFault;
        end else if (charValid) begin
          // stray text outside a frame
          cur_nxt.verdictValid = 1'b1; // see R14
          cur_nxt.verdictReject = 1'b1;
          cur_nxt.errorCode = error_class_pkg::CODE_SYNTAX;
        end
      end
      TEXT: begin
        // frame time counts from the start mark
        cur_nxt.timer = cur_r.timer + 18'h00001;
        if (cur_r.timer >= 18'(TIMEOUT_CYC - 1)) begin
          // give up on the frame and go back to waiting
          cur_nxt.phase = IDLE; // see R13
          cur_nxt.verdictValid = 1'b1;
          cur_nxt.verdictReject = 1'b1;
          cur_nxt.errorCode = error_class_pkg::CODE_TIMEOUT;
        end else if (charValid && charData == error_class_pkg::CHAR_EOT) begin
          cur_nxt.phase = IDLE; // see R17
          cur_nxt.verdictValid = 1'b1;
          cur_nxt.verdictReject = 1'b1;
          // link faults outrank the field checks
          if (cur_r.uartErr || uartFault) begin
            cur_nxt.errorCode = error_class_pkg::CODE_OVERRUN; // see R12
          end else if (cur_r.lengthOver) begin
            cur_nxt.errorCode = error_class_pkg::CODE_LENGTH; // see R15
          end else if (!bccMatch) begin
            cur_nxt.errorCode = error_class_pkg::CODE_CHECK; // see R16
          end else if (cur_r.badChar) begin
            cur_nxt.errorCode = error_class_pkg::CODE_CONVERT; // see R2
          end else begin
            cur_nxt.errorCode = fieldCode;
            cur_nxt.verdictReject = fieldCode != error_class_pkg::CODE_NONE;
          end
        end else if (charValid && charData == error_class_pkg::CHAR_ENQ) begin
          // a new start inside a frame breaks the syntax; restart on it
          cur_nxt.verdictValid = 1'b1; // see R14
          cur_nxt.verdictReject = 1'b1;
          cur_nxt.errorCode = error_class_pkg::CODE_SYNTAX;
          cur_nxt.textCount = error_class_pkg::COUNT_ZERO;
          cur_nxt.timer = error_class_pkg::TIMER_ZERO;
          cur_nxt.badChar = 1'b0;
          cur_nxt.lengthOver = 1'b0;
          cur_nxt.uartErr = uartFault;
        end else if (charValid) begin
          // text past the limit is flagged, not counted
          if (cur_r.textCount >= error_class_pkg::MAX_FRAME_TEXT) begin
            cur_nxt.lengthOver = 1'b1; // see R15
          end else begin
            cur_nxt.textCount = cur_r.textCount + 9'h001;
          end
          // only letters, digits, percent, comma and dot are legal
          if (!(isLetter || isDigit || charData == error_class_pkg::CHAR_PERCENT ||
                charData == error_class_pkg::CHAR_COMMA || charData == error_class_pkg::CHAR_DOT)) begin
            cur_nxt.badChar = 1'b1; // see R2
          end
        end
      end
      default: begin
        // unreachable phase code falls back to waiting
        cur_nxt.phase = IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '{phase: IDLE,
        textCount: error_class_pkg::COUNT_ZERO,
        timer: error_class_pkg::TIMER_ZERO,
        badChar: 1'b0,
        lengthOver: 1'b0,
        uartErr: 1'b0,
        verdictValid: 1'b0,
        verdictReject: 1'b0,
        errorCode: error_class_pkg::CODE_NONE};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // outputs come straight from the state register
  assign verdictValid = cur_r.verdictValid;
  assign verdictReject = cur_r.verdictReject;
  assign errorCode = cur_r.errorCode;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // frame level checks, plus system code, data size, monitor number and illegal character checks
  timeout_code_a: assert property (@(posedge clk) disable iff (!rst_n) // see R13
    (cur_r.phase == TEXT && cur_r.timer >= 18'(TIMEOUT_CYC - 1)) |=>
      verdictValid && errorCode == error_class_pkg::CODE_TIMEOUT && cur_r.phase == IDLE)
    else $error("timeout not reported");
  overrun_code_a: assert property (@(posedge clk) disable iff (!rst_n) // see R12
    (cur_r.phase == TEXT && cur_r.uartErr && charValid && charData == error_class_pkg::CHAR_EOT &&
     cur_r.timer < 18'(TIMEOUT_CYC - 1)) |=> errorCode == error_class_pkg::CODE_OVERRUN)
    else $error("overrun not reported");
  length_code_a: assert property (@(posedge clk) disable iff (!rst_n) // see R15
    (verdictValid && errorCode == error_class_pkg::CODE_LENGTH) |-> $past(cur_r.lengthOver))
    else $error("length code without long frame");
  check_char_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
    (verdictValid && errorCode == error_class_pkg::CODE_CHECK) |-> !$past(bccMatch))
    else $error("check code with matching bcc");
  one_code_a: assert property (@(posedge clk) disable iff (!rst_n) // see R17
    verdictValid |-> (verdictReject == (errorCode != error_class_pkg::CODE_NONE)))
    else $error("reject flag and code disagree");
  single_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // see R17
    (verdictValid && !charValid) |=> !verdictValid)
    else $error("verdict strobe longer than one cycle");
  enq_restart_a: assert property (@(posedge clk) disable iff (!rst_n) // see R14
    (cur_r.phase == TEXT && charValid && charData == error_class_pkg::CHAR_ENQ &&
     cur_r.timer < 18'(TIMEOUT_CYC - 1)) |=>
      (errorCode == error_class_pkg::CODE_SYNTAX && verdictReject && cur_r.phase == TEXT))
    else $error("start mark inside frame not reported");
  stray_text_a: assert property (@(posedge clk) disable iff (!rst_n) // see R14
    (cur_r.phase == IDLE && charValid && charData != error_class_pkg::CHAR_ENQ) |=>
      errorCode == error_class_pkg::CODE_SYNTAX && verdictReject)
    else $error("text outside frame accepted");
  system_code_a: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    (verdictValid && verdictReject && errorCode == error_class_pkg::CODE_SYSTEM) |-> !$past(coreReady))
    else $error("system code while core ready");
  data_size_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    (verdictValid && !verdictReject) |-> ($past(dataBytes) != 9'h000 && $past(dataBytes) <= 9'h080))
    else $error("bad data size accepted");
  monitor_no_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    (verdictValid && !verdictReject) |-> !($past(monitorCmd) && $past(monitorNo) > 4'h9))
    else $error("monitor number above nine accepted");
  bad_char_a: assert property (@(posedge clk) disable iff (!rst_n) // see R2
    (verdictValid && !verdictReject) |-> !$past(cur_r.badChar))
    else $error("illegal character accepted");

  ////////////////////////////////////////////////////////////////////////
  // field legality on accepted verdicts
  core_ready_a: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    (verdictValid && !verdictReject) |-> $past(coreReady))
    else $error("request served while core unreachable");
  cmd_letter_a: assert property (@(posedge clk) disable iff (!rst_n) // see R3
    (verdictValid && !verdictReject) |-> (($past(cmdLetter) | 8'h20) inside {8'h77, 8'h72, 8'h78, 8'h79, 8'h73}))
    else $error("unknown command letter accepted");
  cmd_type_a: assert property (@(posedge clk) disable iff (!rst_n) // see R4
    (verdictValid && !verdictReject) |-> ($past(typeIndividual) || $past(typeBlock)))
    else $error("unknown command type accepted");
  area_letter_a: assert property (@(posedge clk) disable iff (!rst_n) // see R5
    (verdictValid && !verdictReject) |-> (($past(areaLetter) | 8'h20) inside {8'h6D, 8'h71, 8'h69}))
    else $error("unknown memory area accepted");
  data_type_a: assert property (@(posedge clk) disable iff (!rst_n) // see R7
    (verdictValid && !verdictReject) |-> (($past(typeLetter) | 8'h20) inside {8'h78, 8'h77}))
    else $error("refused data type accepted");
  format_check_a: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    (verdictValid && !verdictReject) |-> ($past(percentSeen) && !($past(outputBitRequest) && !$past(dotsSeen))))
    else $error("bad variable format accepted");
  area_range_a: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    (verdictValid && !verdictReject) |->
      ($past(addrDecimal) && !$past(addrOverMemory) && !($past(outputBitRequest) && $past(outputBitIndex) >= 7'h40)))
    else $error("address beyond area accepted");
  block_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    (verdictValid && !verdictReject) |-> !($past(blockReadCommand) && ($past(typeLetter) | 8'h20) == 8'h78))
    else $error("bit type in block read accepted");
endmodule
`default_nettype wire

// ---- serial_request_error_classifier_tb.sv ----
/*
  self-checking bench for the request error classifier.
  assumes the host model frames the text and fields hold from start to verdict.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_request_error_classifier_tb;
  ////////////////////////////////////////////////////////////
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, flt = 1'b0, core = 1'b1;
  logic [1:0] mode = 2'h0; // frame shape
  logic [9:0] len = 10'h004; // text length
  logic [7:0] txt = 8'h31, cmd = 8'h72, area = 8'h4D, dtype = 8'h57, cData;
  logic tInd = 1'b1, tBlk = 1'b0, pct = 1'b1, obr = 1'b0, dots = 1'b1, dec = 1'b1;
  logic over = 1'b0, mon = 1'b0, mexe = 1'b0, brc = 1'b0, bcc = 1'b1, cValid;
  logic [8:0] bytes = 9'h002; // data count
  logic [6:0] bitIdx = 7'h00; // output bit index
  logic [3:0] monNo = 4'h0; // monitor number
  logic vValid, vRej; // verdict
  logic [15:0] code; // reported code
  int err_total = 0, compares = 0;
  string s = "wrxysWRXYS";
  // 200 MHz clock
  always #2.5 clk = ~clk;
  host_frame_model i_host (.clk(clk), .rst_n(rst_n), .go(go), .mode(mode), .textLen(len),
    .textChar(txt), .charValid(cValid), .charData(cData));
  serial_request_error_classifier #(.TIMEOUT_CYC(300)) i_dut (.clk(clk), .rst_n(rst_n),
    .charValid(cValid), .charData(cData), .uartFault(flt), .coreReady(core), .cmdLetter(cmd),
    .typeIndividual(tInd), .typeBlock(tBlk), .areaLetter(area), .typeLetter(dtype),
    .dataBytes(bytes), .percentSeen(pct), .outputBitRequest(obr), .dotsSeen(dots),
    .addrDecimal(dec), .outputBitIndex(bitIdx), .addrOverMemory(over), .monitorCmd(mon),
    .monitorExec(mexe), .monitorNo(monNo), .blockReadCommand(brc), .bccMatch(bcc),
    .verdictValid(vValid), .verdictReject(vRej), .errorCode(code));
  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // back to a legal request
  task automatic legal();
    @(posedge clk) core <= 1'b1;
    {mode, len, txt, cmd, area, dtype} <= {2'h0, 10'h004, 8'h31, 8'h72, 8'h4D, 8'h57};
    {tInd, tBlk, pct, obr, dots, dec, over, mon, mexe, brc, bcc} <= 11'h561;
    {bytes, bitIdx, monNo} <= {9'h002, 7'h00, 4'h0};
  endtask
  // one frame, optional fault pulse, bounded wait, compare, restore
  task automatic run(input string what, input logic [15:0] exp, input logic f);
    int n;
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    @(posedge clk) flt <= f;
    @(posedge clk) flt <= 1'b0;
    #1;
    for (n = 0; n < 600 && vValid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 600) begin
      err_total++;
      wrap_up();
    end else begin
      check(what, code, exp);
      check("reject", {15'h0000, vRej}, {15'h0000, exp != 16'h0000});
      @(posedge clk);
      #1;
      check("pulse", {15'h0000, vValid}, 16'h0000);
      check("hold", code, exp);
      legal();
    end
  endtask
  ////////////////////////////////////////////////////////////
  // command letters, type, core link, characters
  task automatic cmdCheck();
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) cmd <= s[i];
      run("cmd ok", 16'h0000, 1'b0);
    end
    @(posedge clk) cmd <= 8'h41;
    run("cmd", 16'h0021, 1'b0);
    @(posedge clk) tInd <= 1'b0;
    run("type", 16'h0031, 1'b0);
    @(posedge clk) core <= 1'b0;
    run("core", 16'h0001, 1'b0);
    @(posedge clk) txt <= 8'h23;
    run("char", 16'h0011, 1'b0);
  endtask
  // area, format, address range
  task automatic areaCheck();
    @(posedge clk) area <= 8'h5A;
    run("area", 16'h1132, 1'b0);
    @(posedge clk) pct <= 1'b0;
    run("percent", 16'h7132, 1'b0);
    @(posedge clk) obr <= 1'b1;
    dots <= 1'b0;
    run("dots", 16'h7132, 1'b0);
    @(posedge clk) obr <= 1'b1;
    bitIdx <= 7'h3F;
    run("bit 63", 16'h0000, 1'b0);
    @(posedge clk) obr <= 1'b1;
    bitIdx <= 7'h40;
    run("bit 64", 16'h2232, 1'b0);
    @(posedge clk) dec <= 1'b0;
    run("decimal", 16'h2232, 1'b0);
    @(posedge clk) over <= 1'b1;
    run("mem size", 16'h2232, 1'b0);
  endtask
  // size, data type, block read, monitor numbers
  task automatic sizeCheck();
    @(posedge clk) bytes <= 9'h000;
    run("size 0", 16'h1232, 1'b0);
    @(posedge clk) bytes <= 9'h080;
    run("size 128", 16'h0000, 1'b0);
    @(posedge clk) bytes <= 9'h081;
    run("size 129", 16'h1232, 1'b0);
    @(posedge clk) dtype <= 8'h64;
    run("dtype d", 16'h2432, 1'b0);
    @(posedge clk) dtype <= 8'h42;
    run("dtype b", 16'h2432, 1'b0);
    @(posedge clk) brc <= 1'b1;
    dtype <= 8'h58;
    run("block bit", 16'h6001, 1'b0);
    @(posedge clk) mon <= 1'b1;
    monNo <= 4'h9;
    run("mon 9", 16'h0000, 1'b0);
    @(posedge clk) mon <= 1'b1;
    {mexe, monNo} <= 5'h1A;
    run("mon exec", 16'h0190, 1'b0);
    @(posedge clk) mon <= 1'b1;
    monNo <= 4'hA;
    run("mon reg", 16'h0290, 1'b0);
  endtask
  // link faults, framing, length, timeout, recovery
  task automatic linkCheck();
    run("fault", 16'h6010, 1'b1);
    @(posedge clk) bcc <= 1'b0;
    run("bcc", 16'h6050, 1'b0);
    @(posedge clk) bcc <= 1'b0;
    run("fault first", 16'h6010, 1'b1);
    @(posedge clk) mode <= 2'h1;
    run("timeout", 16'h6020, 1'b0);
    @(posedge clk) {mode, len} <= {2'h2, 10'h000};
    run("no start", 16'h6030, 1'b0);
    @(posedge clk) len <= 10'h100;
    run("len 256", 16'h0000, 1'b0);
    @(posedge clk) len <= 10'h101;
    run("len 257", 16'h6040, 1'b0);
    @(posedge clk) {mode, len, txt} <= {2'h1, 10'h001, 8'h05};
    run("enq in frame", 16'h6030, 1'b0);
    for (int k = 0; k < 600 && vValid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("restart timeout", code, 16'h6020);
    run("recover", 16'h0000, 1'b0);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cmdCheck();
    areaCheck();
    sizeCheck();
    linkCheck();
    wrap_up();
  end
endmodule
`default_nettype wire
